// File: src/psens_pkg.sv
package psens_pkg;

  // System clock and derived cycle counts (least times round up).
  localparam int CLK_NS       = 8;
  localparam int SCLK_HALF_NS = 1000;
  localparam int HDSS_NS      = 2500;
  localparam int SUSS_NS      = 100;
  localparam int BUS_FREE_NS  = 2000;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int HDSS_CYC      = (HDSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSS_CYC      = (SUSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUS_FREE_CYC  = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;

  // Serial clock limits against the internal oscillator setting.
  localparam int INT_OSC_KHZ       = 4000;
  localparam int SCLK_MIN_KHZ      = 50;
  localparam int SCLK_MAX_KHZ_4MHZ = 800;
  localparam int SCLK_MAX_KHZ_1MHZ = 200;
  localparam int SCLK_KHZ          = 1000000 / (2 * SCLK_HALF_NS);

  // Measurement response times and their cycle counts.
  localparam int FULL_MEAS_US   = 1500;
  localparam int BRIDGE_MEAS_US = 500;
  localparam int FULL_MEAS_CYC   = (FULL_MEAS_US * 1000) / CLK_NS;
  localparam int BRIDGE_MEAS_CYC = (BRIDGE_MEAS_US * 1000) / CLK_NS;

  // Packet layout.
  localparam int PKT_BITS       = 32;
  localparam int BYTE_BITS      = 8;
  localparam int MIN_FETCH_BITS = 16;
  localparam int BRIDGE_W       = 14;
  localparam int TEMP_W         = 11;
  localparam int PAD_W          = 5;

  // Status field codes and output code range.
  localparam logic [1:0]  STATUS_VALID = 2'h0;
  localparam logic [1:0]  STATUS_STALE = 2'h2;
  localparam logic [13:0] CODE_MIN     = 14'h0666;
  localparam logic [13:0] CODE_MAX     = 14'h399A;
  localparam logic [13:0] CODE_FULL    = 14'h3FFF;

  // Sensor measurement sequencer states.
  typedef enum logic [2:0] {
    MEAS_SLEEP  = 3'h0,
    MEAS_TEMP   = 3'h1,
    MEAS_NULL   = 3'h2,
    MEAS_BRIDGE = 3'h3,
    MEAS_CORR   = 3'h4
  } meas_state_t;

  // Master link states.
  typedef enum logic [2:0] {
    LINK_IDLE  = 3'h0,
    LINK_SETUP = 3'h1,
    LINK_HIGH  = 3'h2,
    LINK_LOW   = 3'h3,
    LINK_HOLD  = 3'h4,
    LINK_GAP   = 3'h5
  } link_state_t;

  // One received packet as handed to the master's user.
  typedef struct packed {
    logic [1:0]          status;
    logic [BRIDGE_W-1:0] bridge;
    logic [TEMP_W-1:0]   temp;
    logic [2:0]          nbytes;
  } pkt_t;

endpackage

// File: src/psens_spi_if.sv
`timescale 1ns/1ps
`default_nettype none

interface psens_spi_if;
  logic sclk;
  logic ss_n;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // The data line floats high through a pull-up while the sensor does not drive it.
  assign miso = miso_oe ? miso_out : 1'b1;

  modport sensor (input sclk, input ss_n, output miso_out, output miso_oe);
  modport master (output sclk, output ss_n, input miso);
endinterface

`default_nettype wire

// File: src/psens_sensor.sv
// How it works
// - Read-only half-duplex link, sensor only transmits.
// - Default falling-edge polarity, 4 MHz internal clock.
// - Master keeps serial clock 50 to 800 kHz.
// - At 1 MHz internal clock, 200 kHz max.
// - Select low 2.5 us before first clock.
// - At least 2 us bus-free between frames.
// - Data bit changes only after falling edge.
// - Master samples data on rising edge.
// - 32-bit packet, bridge high byte first.
// - Temperature bits 10..3, then 2..0 on top.
// - Master drops five low bits of byte four.
// - Reads may stop after byte two or three.
// - Bridge is 14-bit code within full scale.
// - Asleep until a measurement request wakes it.
// - Full request: temperature, nulling, bridge, correction.
// - Bridge-only request reuses stored temperature and nulling.
// - Results stored, then sensor sleeps again.
// - Fetch returns last result without waking.
// - First fetch valid, afterwards status turns stale.
// - Fetch during measurement reports stale status.
// - Master polls no faster than response plus 20%; psens_master accepts a fetch whenever o_cmd_ready is high.
// - Bridge-only first after reset still reports valid.
`timescale 1ns/1ps
`default_nettype none

module psens_sensor
  import psens_pkg::*;
#(
  parameter int P_FULL_CYC   = FULL_MEAS_CYC,
  parameter int P_BRIDGE_CYC = BRIDGE_MEAS_CYC
) (
  // Clock and reset.
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  // Serial link.
  psens_spi_if.sensor              spi,
  // Converter samples and second-port request.
  input  wire logic [TEMP_W-1:0]   i_temp_sample,
  input  wire logic [BRIDGE_W-1:0] i_offset_sample,
  input  wire logic [BRIDGE_W-1:0] i_bridge_sample,
  input  wire logic                i_bridge_only_req,
  // Status.
  output logic                     o_awake,
  output logic                     o_result_ready,
  output logic [2:0]               o_meas_state
);

  localparam int TIMER_W = 18;

  typedef struct packed {
    logic                ss_s1;
    logic                ss_s2;
    logic                ss_d;
    logic                sclk_s1;
    logic                sclk_s2;
    logic                sclk_d;
    logic [PKT_BITS-1:0] shift;
    logic [5:0]          nfall;
    logic                frame_valid;
    logic                miso;
    logic                oe;
    meas_state_t         mstate;
    logic                full;
    logic [TIMER_W-1:0]  timer;
    logic [TEMP_W-1:0]   temp_st;
    logic [BRIDGE_W-1:0] null_st;
    logic [BRIDGE_W-1:0] bridge_raw;
    logic [BRIDGE_W-1:0] res_bridge;
    logic [TEMP_W-1:0]   res_temp;
    logic                fresh;
    logic                ready;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Offset-nulled bridge code, shifted to the bottom of the span and clamped.
  function automatic logic [BRIDGE_W-1:0] correct(input logic [BRIDGE_W-1:0] raw,
                                                  input logic [BRIDGE_W-1:0] nul);
    logic signed [BRIDGE_W+1:0] sum;
    sum = $signed({2'h0, raw}) - $signed({2'h0, nul}) + $signed({2'h0, CODE_MIN});
    if (sum < 0) begin
      correct = 14'h0000;
    end else if (sum > $signed({2'h0, CODE_FULL})) begin
      correct = CODE_FULL;
    end else begin
      correct = sum[BRIDGE_W-1:0];
    end
  endfunction

  // Next-state logic for the serial frame and the measurement sequencer.
  always_comb begin
    logic                ss_fall;
    logic                ss_rise;
    logic                sclk_fall;
    logic                start_full;
    logic [1:0]          status;
    logic [TIMER_W-1:0]  phase_last;
    logic [PKT_BITS-1:0] pkt;
    ss_fall    = 1'b0;
    ss_rise    = 1'b0;
    sclk_fall  = 1'b0;
    start_full = 1'b0;
    status     = STATUS_STALE;
    phase_last = '0;
    pkt        = '0;
    state_next = state_reg;

    // Two-stage synchronisers, then one delay stage for edge detection.
    state_next.ss_s1   = spi.ss_n;
    state_next.ss_s2   = state_reg.ss_s1;
    state_next.ss_d    = state_reg.ss_s2;
    state_next.sclk_s1 = spi.sclk;
    state_next.sclk_s2 = state_reg.sclk_s1;
    state_next.sclk_d  = state_reg.sclk_s2;
    ss_fall   = state_reg.ss_d & ~state_reg.ss_s2;
    ss_rise   = ~state_reg.ss_d & state_reg.ss_s2;
    sclk_fall = state_reg.sclk_d & ~state_reg.sclk_s2;

    // A fetch reports valid only for a finished, not yet fetched result.
    if (state_reg.fresh && (state_reg.mstate == MEAS_SLEEP)) begin
      status = STATUS_VALID;
    end
    pkt = {status, state_reg.res_bridge, state_reg.res_temp, {PAD_W{1'b0}}};

    // Serial frame: first bit appears with select, later bits after falling edges.
    if (ss_fall) begin
      state_next.shift       = pkt;
      state_next.miso        = pkt[PKT_BITS-1];
      state_next.oe          = 1'b1;
      state_next.nfall       = 6'h00;
      state_next.frame_valid = (status == STATUS_VALID);
    end else if (!state_reg.ss_s2 && sclk_fall) begin
      state_next.shift = {state_reg.shift[PKT_BITS-2:0], 1'b0};
      state_next.miso  = state_reg.shift[PKT_BITS-2];
      if (state_reg.nfall != 6'h3F) begin
        state_next.nfall = state_reg.nfall + 6'h01;
      end
    end

    // Frame end: no clocks means a full request, otherwise a fetch.
    if (ss_rise) begin
      state_next.oe = 1'b0;
      if (state_reg.nfall == 6'h00) begin
        start_full = 1'b1;
      end else if (({26'h0, state_reg.nfall} >= MIN_FETCH_BITS) &&
                   state_reg.frame_valid) begin
        state_next.fresh = 1'b0;
        state_next.ready = 1'b0;
      end
    end

    // Full requests split the response time over three converter phases.
    if (state_reg.full) begin
      phase_last = TIMER_W'(P_FULL_CYC / 3 - 1);
    end else begin
      phase_last = TIMER_W'(P_BRIDGE_CYC - 1);
    end

    // Measurement sequencer; a request while awake is ignored.
    case (state_reg.mstate)
      MEAS_SLEEP: begin
        state_next.timer = '0;
        if (start_full) begin
          state_next.full   = 1'b1;
          state_next.mstate = MEAS_TEMP;
        end else if (i_bridge_only_req) begin
          state_next.full   = 1'b0;
          state_next.mstate = MEAS_BRIDGE;
        end
      end
      MEAS_TEMP: begin
        state_next.timer = state_reg.timer + 1'b1;
        if (state_reg.timer == phase_last) begin
          state_next.temp_st = i_temp_sample;
          state_next.timer   = '0;
          state_next.mstate  = MEAS_NULL;
        end
      end
      MEAS_NULL: begin
        state_next.timer = state_reg.timer + 1'b1;
        if (state_reg.timer == phase_last) begin
          state_next.null_st = i_offset_sample;
          state_next.timer   = '0;
          state_next.mstate  = MEAS_BRIDGE;
        end
      end
      MEAS_BRIDGE: begin
        state_next.timer = state_reg.timer + 1'b1;
        if (state_reg.timer == phase_last) begin
          state_next.bridge_raw = i_bridge_sample;
          state_next.timer      = '0;
          state_next.mstate     = MEAS_CORR;
        end
      end
      MEAS_CORR: begin
        // Stored temperature and nulling value serve bridge-only cycles too.
        state_next.res_bridge = correct(state_reg.bridge_raw, state_reg.null_st);
        state_next.res_temp   = state_reg.temp_st;
        state_next.fresh      = 1'b1;
        state_next.ready      = 1'b1;
        state_next.mstate     = MEAS_SLEEP;
      end
      default: begin
        state_next.mstate = MEAS_SLEEP;
      end
    endcase
  end

  // State register; everything resets to constants.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg         <= '0;
      state_reg.ss_s1   <= 1'b1;
      state_reg.ss_s2   <= 1'b1;
      state_reg.ss_d    <= 1'b1;
      state_reg.miso    <= 1'b1;
      state_reg.mstate  <= MEAS_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs; the link never samples anything driven toward the sensor's data pin.
  assign spi.miso_out   = state_reg.miso;
  assign spi.miso_oe    = state_reg.oe;
  assign o_awake        = (state_reg.mstate != MEAS_SLEEP);
  assign o_result_ready = state_reg.ready;
  assign o_meas_state   = state_reg.mstate;

endmodule

`default_nettype wire

// File: src/psens_master.sv
`timescale 1ns/1ps
`default_nettype none

module psens_master
  import psens_pkg::*;
(
  // Clock and reset.
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  // Serial link.
  psens_spi_if.master              spi,
  // Commands.
  input  wire logic                i_measure_req,
  input  wire logic                i_fetch_req,
  input  wire logic [2:0]          i_fetch_bytes,
  output logic                     o_cmd_ready,
  // Received packets.
  output logic                     o_pkt_valid,
  input  wire logic                i_pkt_ready,
  output logic [1:0]               o_pkt_status,
  output logic [BRIDGE_W-1:0]      o_pkt_bridge,
  output logic [TEMP_W-1:0]        o_pkt_temp,
  output logic [2:0]               o_pkt_nbytes
);

  typedef struct packed {
    link_state_t         lstate;
    logic [8:0]          timer;
    logic                sclk;
    logic                ss_n;
    logic                miso_s1;
    logic                miso_s2;
    logic                fetch;
    logic [5:0]          bits_left;
    logic [2:0]          nbytes;
    logic [PKT_BITS-1:0] shift;
    pkt_t [1:0]          fifo;
    logic                wr_ptr;
    logic                rd_ptr;
    logic [1:0]          count;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Link sequencing, packet alignment and the two-entry output buffer.
  always_comb begin
    logic                push;
    logic                pop;
    logic [2:0]          nb;
    logic [PKT_BITS-1:0] al;
    push = 1'b0;
    pop  = o_pkt_valid && i_pkt_ready;
    nb   = i_fetch_bytes;
    al   = '0;
    state_next = state_reg;
    state_next.miso_s1 = spi.miso;
    state_next.miso_s2 = state_reg.miso_s1;
    state_next.timer   = state_reg.timer + 9'h001;
    if (nb < 3'h2) begin
      nb = 3'h2;
    end else if (nb > 3'h4) begin
      nb = 3'h4;
    end

    case (state_reg.lstate)
      LINK_IDLE: begin
        state_next.timer = 9'h000;
        if (o_cmd_ready && i_fetch_req) begin
          state_next.fetch     = 1'b1;
          state_next.nbytes    = nb;
          state_next.bits_left = {nb, 3'h0};
          state_next.ss_n      = 1'b0;
          state_next.lstate    = LINK_SETUP;
        end else if (o_cmd_ready && i_measure_req) begin
          state_next.fetch  = 1'b0;
          state_next.ss_n   = 1'b0;
          state_next.lstate = LINK_SETUP;
        end
      end
      LINK_SETUP: begin
        if (state_reg.timer == 9'(HDSS_CYC - 1)) begin
          state_next.timer = 9'h000;
          if (state_reg.fetch) begin
            // Rising edge samples the bit the sensor set up earlier.
            state_next.sclk      = 1'b1;
            state_next.shift     = {state_reg.shift[PKT_BITS-2:0], state_reg.miso_s2};
            state_next.bits_left = state_reg.bits_left - 6'h01;
            state_next.lstate    = LINK_HIGH;
          end else begin
            state_next.lstate = LINK_HOLD;
          end
        end
      end
      LINK_HIGH: begin
        if (state_reg.timer == 9'(SCLK_HALF_CYC - 1)) begin
          state_next.timer = 9'h000;
          state_next.sclk  = 1'b0;
          state_next.lstate = (state_reg.bits_left == 6'h00) ? LINK_HOLD : LINK_LOW;
        end
      end
      LINK_LOW: begin
        if (state_reg.timer == 9'(SCLK_HALF_CYC - 1)) begin
          state_next.timer     = 9'h000;
          state_next.sclk      = 1'b1;
          state_next.shift     = {state_reg.shift[PKT_BITS-2:0], state_reg.miso_s2};
          state_next.bits_left = state_reg.bits_left - 6'h01;
          state_next.lstate    = LINK_HIGH;
        end
      end
      LINK_HOLD: begin
        if (state_reg.timer == 9'(SUSS_CYC - 1)) begin
          state_next.timer  = 9'h000;
          state_next.ss_n   = 1'b1;
          state_next.lstate = LINK_GAP;
          push = state_reg.fetch;
        end
      end
      LINK_GAP: begin
        if (state_reg.timer == 9'(BUS_FREE_CYC - 1)) begin
          state_next.lstate = LINK_IDLE;
        end
      end
      default: begin
        state_next.lstate = LINK_IDLE;
      end
    endcase

    // Left-align a short read; the five pad bits are never kept.
    al = state_reg.shift << (6'(PKT_BITS) - {state_reg.nbytes, 3'h0});
    if (push) begin
      state_next.fifo[state_reg.wr_ptr].status = al[31:30];
      state_next.fifo[state_reg.wr_ptr].bridge = al[29:16];
      state_next.fifo[state_reg.wr_ptr].temp   = al[15:5];
      state_next.fifo[state_reg.wr_ptr].nbytes = state_reg.nbytes;
      state_next.wr_ptr = ~state_reg.wr_ptr;
    end
    if (pop) begin
      state_next.rd_ptr = ~state_reg.rd_ptr;
    end
    state_next.count = state_reg.count + {1'b0, push} - {1'b0, pop};
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg        <= '0;
      state_reg.ss_n   <= 1'b1;
      state_reg.lstate <= LINK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // A new command waits for an idle link and buffer room, so no packet is lost.
  assign o_cmd_ready  = (state_reg.lstate == LINK_IDLE) && (state_reg.count != 2'h2);
  assign o_pkt_valid  = (state_reg.count != 2'h0);
  assign o_pkt_status = state_reg.fifo[state_reg.rd_ptr].status;
  assign o_pkt_bridge = state_reg.fifo[state_reg.rd_ptr].bridge;
  assign o_pkt_temp   = state_reg.fifo[state_reg.rd_ptr].temp;
  assign o_pkt_nbytes = state_reg.fifo[state_reg.rd_ptr].nbytes;
  assign spi.sclk     = state_reg.sclk;
  assign spi.ss_n     = state_reg.ss_n;

endmodule

`default_nettype wire

// File: tb/psens_readout_properties.sv
`timescale 1ns/1ps
`default_nettype none

module psens_readout_properties
  import psens_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_nrst,
  // Link signals.
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  localparam int HDSS_M  = HDSS_CYC - 2;
  localparam int FREE_M  = BUS_FREE_CYC - 2;
  localparam int SUSS_M  = SUSS_CYC - 2;
  localparam int LVL_MIN = 600 / CLK_NS - 2;
  localparam int LVL_MAX = 2500;

  typedef struct packed {
    logic        sclk_d;
    logic        first;
    logic [11:0] gap;
    logic [11:0] sel;
    logic [11:0] lvl;
  } mon_t;

  mon_t mon_reg;
  mon_t mon_next;

  // Saturating counters of idle time, select time and serial clock level time.
  always_comb begin
    mon_next        = mon_reg;
    mon_next.sclk_d = sclk;
    mon_next.gap    = !ss_n ? 12'h000 : mon_reg.gap + {11'h000, mon_reg.gap != 12'hFFF};
    mon_next.sel    = ss_n ? 12'h000 : mon_reg.sel + {11'h000, mon_reg.sel != 12'hFFF};
    mon_next.lvl    = (sclk != mon_reg.sclk_d) ? 12'h000 :
                      mon_reg.lvl + {11'h000, mon_reg.lvl != 12'hFFF};
    if (ss_n) begin
      mon_next.first = 1'b1;
    end else if (sclk && !mon_reg.sclk_d) begin
      mon_next.first = 1'b0;
    end
  end

  // Counters start as if the bus had been idle for a long time.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mon_reg <= '{1'b0, 1'b1, 12'hFFF, 12'h000, 12'hFFF};
    end else begin
      mon_reg <= mon_next;
    end
  end

  sequence sel_start;
    $fell(ss_n);
  endsequence

  sequence first_clk;
    $rose(sclk) && mon_reg.first;
  endsequence

  chk_oe_released: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ss_n [*8] |-> !miso_oe && miso) else $error("data line driven while deselected");
  chk_sclk_idle_low: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ss_n |-> !sclk) else $error("serial clock not low while deselected");
  chk_data_stable: assert property (@(posedge i_clock) disable iff (!i_nrst)
    sclk && $past(sclk) && !ss_n |-> $stable(miso_out) && $stable(miso))
    else $error("data moved in high phase");
  chk_oe_on_select: assert property (@(posedge i_clock) disable iff (!i_nrst)
    sel_start |-> ##[2:8] miso_oe) else $error("sensor did not drive data line");
  chk_select_hold: assert property (@(posedge i_clock) disable iff (!i_nrst)
    first_clk |-> mon_reg.sel >= HDSS_M) else $error("first clock too soon after select");
  chk_bus_free: assert property (@(posedge i_clock) disable iff (!i_nrst)
    sel_start |-> mon_reg.gap >= FREE_M) else $error("bus free time too short");
  chk_clock_width: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $changed(sclk) && !(sclk && mon_reg.first) |-> mon_reg.lvl inside {[LVL_MIN:LVL_MAX]})
    else $error("serial clock phase width out of range");
  chk_deselect_setup: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $rose(ss_n) |-> !sclk && mon_reg.lvl >= SUSS_M) else $error("select rose too early");
endmodule

`default_nettype wire

// File: tb/tb_pressure_sensor_spi_readout.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pressure_sensor_spi_readout;
  import psens_pkg::*;
  logic                i_clock   = 1'b0;
  logic                i_nrst    = 1'b0;
  logic [TEMP_W-1:0]   temp_s    = 11'h5A3;
  logic [BRIDGE_W-1:0] off_s     = 14'h0100;
  logic [BRIDGE_W-1:0] br_s      = 14'h2000;
  logic                bo_req    = 1'b0;
  logic                meas_req  = 1'b0;
  logic                fetch_req = 1'b0;
  logic                pkt_ready = 1'b0;
  logic [2:0]          fetch_n   = 3'h2;
  logic                awake, rdy, cmd_ready, pkt_valid;
  logic [2:0]          mstate, pkt_n;
  logic [1:0]          pkt_st;
  logic [BRIDGE_W-1:0] pkt_br;
  logic [TEMP_W-1:0]   pkt_temp;
  logic [19:0]         seq_reg   = 20'h00000;
  int                  fail_count = 0;
  int                  checked    = 0;

  // Free-running system clock.
  always #4 i_clock = ~i_clock;

  psens_spi_if u_psens_spi_if ();

  psens_sensor #(.P_FULL_CYC(600), .P_BRIDGE_CYC(100)) u_psens_sensor (
    .i_clock(i_clock), .i_nrst(i_nrst), .spi(u_psens_spi_if.sensor),
    .i_temp_sample(temp_s), .i_offset_sample(off_s), .i_bridge_sample(br_s),
    .i_bridge_only_req(bo_req), .o_awake(awake), .o_result_ready(rdy), .o_meas_state(mstate));

  psens_master u_psens_master (
    .i_clock(i_clock), .i_nrst(i_nrst), .spi(u_psens_spi_if.master),
    .i_measure_req(meas_req), .i_fetch_req(fetch_req), .i_fetch_bytes(fetch_n),
    .o_cmd_ready(cmd_ready), .o_pkt_valid(pkt_valid), .i_pkt_ready(pkt_ready),
    .o_pkt_status(pkt_st), .o_pkt_bridge(pkt_br), .o_pkt_temp(pkt_temp), .o_pkt_nbytes(pkt_n));

  psens_readout_properties u_psens_readout_properties (
    .i_clock(i_clock), .i_nrst(i_nrst), .sclk(u_psens_spi_if.sclk), .ss_n(u_psens_spi_if.ss_n),
    .miso_out(u_psens_spi_if.miso_out), .miso_oe(u_psens_spi_if.miso_oe),
    .miso(u_psens_spi_if.miso));

  // Records each new sequencer state, one nibble per state, so phase order can be compared.
  always @(posedge i_clock) begin
    if (mstate !== seq_reg[3:0]) begin
      seq_reg <= {seq_reg[15:0], 1'b0, mstate};
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Waits at falling edges for command ready, meaning idle link and buffer room (0), a packet (1) or a stored result (2).
  task automatic wait_until(input int sel);
    int k;
    for (k = 0; k < 20000; k++) begin
      if ((sel == 0 && cmd_ready === 1'b1) || (sel == 1 && pkt_valid === 1'b1) ||
          (sel == 2 && rdy === 1'b1)) break;
      @(negedge i_clock);
    end
    check("wait", 32'(k < 20000), 32'h1);
  endtask

  task automatic do_reset();
    i_nrst = 1'b0;
    repeat (20) @(negedge i_clock);
    i_nrst = 1'b1;
  endtask

  task automatic cmd(input logic meas, input logic fetch, input logic [2:0] n);
    wait_until(0);
    meas_req  = meas;
    fetch_req = fetch;
    fetch_n   = n;
    @(negedge i_clock);
    meas_req  = 1'b0;
    fetch_req = 1'b0;
  endtask

  task automatic bridge_only();
    bo_req  = 1'b1;
    @(negedge i_clock);
    bo_req  = 1'b0;
    wait_until(2);
    repeat (2) @(negedge i_clock);
  endtask

  task automatic pop(input logic [1:0] st, input logic [13:0] br, input logic [10:0] t,
                     input logic [2:0] n);
    wait_until(1);
    check("status", 32'(pkt_st), 32'(st));
    check("bridge", 32'(pkt_br), 32'(br));
    check("temp", 32'(pkt_temp), 32'(t));
    check("nbytes", 32'(pkt_n), 32'(n));
    pkt_ready = 1'b1;
    @(negedge i_clock);
    pkt_ready = 1'b0;
    // Let an edge pass so a following pop never re-raises ready in the same step.
    @(negedge i_clock);
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge i_clock);
    fail_count++;
    stop_test();
  end

  // Main sequence.
  initial begin
    do_reset();
    check("cmd_ready", 32'(cmd_ready), 32'h1);
    check("awake", 32'(awake), 32'h0);
    cmd(1'b1, 1'b0, 3'h0);
    wait_until(2);
    repeat (2) @(negedge i_clock);
    check("sequence", 32'(seq_reg), 32'h12340);
    check("awake", 32'(awake), 32'h0);
    cmd(1'b0, 1'b1, 3'h4);
    pop(STATUS_VALID, 14'h2566, 11'h5A3, 3'h4);
    // The sensor sees the select rise only after its synchronisers.
    repeat (4) @(negedge i_clock);
    check("result_ready", 32'(rdy), 32'h0);
    cmd(1'b0, 1'b1, 3'h2);
    pop(STATUS_STALE, 14'h2566, 11'h000, 3'h2);
    cmd(1'b0, 1'b1, 3'h3);
    pop(STATUS_STALE, 14'h2566, 11'h5A0, 3'h3);
    br_s = 14'h3F00;
    bridge_only();
    check("sequence", 32'(seq_reg[15:0]), 32'h00340);
    cmd(1'b0, 1'b1, 3'h2);
    pop(STATUS_VALID, 14'h3FFF, 11'h000, 3'h2);
    br_s  = 14'h0050;
    off_s = 14'h1000;
    cmd(1'b1, 1'b0, 3'h0);
    cmd(1'b0, 1'b1, 3'h2);
    wait_until(2);
    cmd(1'b0, 1'b1, 3'h2);
    repeat (4700) @(negedge i_clock);
    check("cmd_ready", 32'(cmd_ready), 32'h0);
    pop(STATUS_STALE, 14'h3FFF, 11'h000, 3'h2);
    pop(STATUS_VALID, 14'h0000, 11'h000, 3'h2);
    do_reset();
    br_s  = 14'h1234;
    bridge_only();
    cmd(1'b0, 1'b1, 3'h2);
    pop(STATUS_VALID, 14'h189A, 11'h000, 3'h2);
    stop_test();
  end
endmodule

`default_nettype wire
